// ===== hdl/opc_top.sv
// Output port conditioner: port configuration store and eight conditioned outputs
//
// Function
// - Eight ports 0-7; reject out-of-range index
// - Edit command updates one port only
// - Single-port reset needs password first
// - Reset-all restores every port, needs password
// - Decide selected condition detected per port
// - Qualify after uninterrupted stability time, 0-1000ms
// - Drive port open/closed from polarity
// - Polarity 0 positive, 1 negative
// - Function none or one listed condition
// - Port zero only driver-ready or normal
// - Port zero polarity and time fixed
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "opc_params.svh"

module opc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  input  wire logic [24:0] status_conditions,
  output logic [7:0]       port_out
);

  // ----------------------------------------------------------------
  // Condition sampling
  // ----------------------------------------------------------------
  // Conditions come from the drive core on this clock; bit 0 is unused
  // so that function code N maps straight onto bit N.
  logic [2:0]  cfg_sel_q;
  logic        unlocked_q;
  logic        last_err_q;
  logic        last_ok_q;

  opc_pkg::opc_port_cfg_t cfg_q [`OPC_NUM_PORTS];

  function automatic logic fn_legal(input logic [2:0] idx, input logic [4:0] fn);
    if (idx == 3'h0) begin
      fn_legal = (fn == `OPC_FN_DRIVER_READY) || (fn == `OPC_FN_NORMAL_STATE);
    end else begin
      fn_legal = (fn <= `OPC_FN_LAST);
    end
  endfunction

  function automatic opc_pkg::opc_port_cfg_t cfg_default(input logic [2:0] idx);
    cfg_default.port_function_select = (idx == 3'h0) ? `OPC_RST_FN_PORT0 : `OPC_RST_FN;
    cfg_default.output_logic_select  = `OPC_RST_POL;
    cfg_default.stability_time       = `OPC_RST_ST;
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  opc_pkg::opc_cmd_t cmd;
  wire wr_cmd  = wr && (addr == `OPC_ADDR_CMD);
  wire wr_pass = wr && (addr == `OPC_ADDR_PASSWORD);

  assign cmd.idx     = wdata[`OPC_CMD_IDX_LSB +: 3];
  assign cmd.idx_bad = wdata[`OPC_CMD_IDX_LSB + 3];
  assign cmd.op      = opc_pkg::opc_op_t'(wdata[`OPC_CMD_OP_LSB +: 2]);
  assign cmd.fn      = wdata[`OPC_CMD_FN_LSB +: 5];
  assign cmd.pol     = wdata[`OPC_CMD_POL_BIT];
  assign cmd.st      = wdata[`OPC_CMD_ST_LSB +: 14];

  wire st_ok   = (cmd.st <= `OPC_ST_MAX);
  // Port zero keeps its polarity and time: any attempt to change them fails
  wire p0_fix  = (cmd.idx != 3'h0) ||
                 ((cmd.pol == `OPC_RST_POL) && (cmd.st == `OPC_RST_ST));
  wire edit_ok = wr_cmd && (cmd.op == opc_pkg::OPC_OP_EDIT) && !cmd.idx_bad &&
                 fn_legal(cmd.idx, cmd.fn) && st_ok && p0_fix;
  wire rs1_ok  = wr_cmd && (cmd.op == opc_pkg::OPC_OP_RESET_ONE) && !cmd.idx_bad &&
                 unlocked_q;
  wire rsa_ok  = wr_cmd && (cmd.op == opc_pkg::OPC_OP_RESET_ALL) && unlocked_q;
  wire cmd_ok  = edit_ok || rs1_ok || rsa_ok;
  wire is_nop  = (cmd.op == opc_pkg::OPC_OP_NOP);

  // ----------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `OPC_NUM_PORTS; i++) begin
        cfg_q[i] <= cfg_default(3'(i));
      end
    end else begin
      for (int i = 0; i < `OPC_NUM_PORTS; i++) begin
        if (rsa_ok || (rs1_ok && cmd.idx == 3'(i))) begin
          cfg_q[i] <= cfg_default(3'(i));
        end else if (edit_ok && cmd.idx == 3'(i)) begin
          cfg_q[i] <= '{cmd.fn, cmd.pol, cmd.st};
        end
      end
    end
  end

  // Password unlocks only the next command write; an edit or no-op there spends it too
  always_ff @(posedge clk) begin
    if (rst) begin
      unlocked_q <= 1'b0;
      last_err_q <= 1'b0;
      last_ok_q  <= 1'b0;
      cfg_sel_q  <= 3'h0;
    end else begin
      if (wr_pass) begin
        unlocked_q <= (wdata == `OPC_PASSWORD_KEY);
      end else if (wr_cmd) begin
        unlocked_q <= 1'b0;
      end
      if (wr_cmd && !is_nop) begin
        last_ok_q  <= cmd_ok;
        last_err_q <= !cmd_ok;
      end
      if (wr && addr == `OPC_ADDR_PORT_CFG) begin
        cfg_sel_q <= wdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Stability time base: one tick per 0.1 ms
  // ----------------------------------------------------------------
  localparam int TICK_N = `OPC_TICK_CYCLES;
  logic [11:0] tick_cnt_q;
  wire         tick = (tick_cnt_q == 12'(TICK_N - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q <= 12'h000;
    end else begin
      tick_cnt_q <= tick ? 12'h000 : tick_cnt_q + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Per-port conditioning
  // ----------------------------------------------------------------
  logic [7:0] detected;
  logic [7:0] qualified;

  genvar g;
  generate
    for (g = 0; g < `OPC_NUM_PORTS; g++) begin : g_port
      // No function leaves the port inactive
      assign detected[g] = (cfg_q[g].port_function_select != `OPC_FN_NONE) &&
                           status_conditions[cfg_q[g].port_function_select];
      opc_stab_filter u_filt (
        .clk                 (clk),
        .rst                 (rst),
        .tick                (tick),
        .detected            (detected[g]),
        .stability_time      (cfg_q[g].stability_time),
        .output_logic_select (cfg_q[g].output_logic_select),
        .port_closed         (port_out[g]),
        .qualified           (qualified[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire opc_pkg::opc_port_cfg_t sel_cfg = cfg_q[cfg_sel_q];
  logic [31:0] rd_mux;

  always_comb begin
    unique case (addr)
      `OPC_ADDR_STATUS:   rd_mux = {29'h0, unlocked_q, last_err_q, last_ok_q};
      `OPC_ADDR_OUT:      rd_mux = {16'h0, qualified, port_out};
      `OPC_ADDR_PORT_CFG: rd_mux = {29'h0, cfg_sel_q};
      `OPC_ADDR_CFG_RD:   rd_mux = {16'h0, 2'h0, sel_cfg.stability_time} << 16 |
                                   {18'h0, sel_cfg.output_logic_select, 8'h0, 5'h0} |
                                   {19'h0, sel_cfg.port_function_select, 8'h0};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_port0_fn;
    @(posedge clk) disable iff (rst)
      (cfg_q[0].port_function_select == `OPC_FN_DRIVER_READY) ||
      (cfg_q[0].port_function_select == `OPC_FN_NORMAL_STATE);
  endproperty
  a_port0_fn: assert property (p_port0_fn) else $error("port zero function illegal");

  property p_port0_fixed;
    @(posedge clk) disable iff (rst)
      (cfg_q[0].output_logic_select == `OPC_RST_POL) &&
      (cfg_q[0].stability_time == `OPC_RST_ST);
  endproperty
  a_port0_fixed: assert property (p_port0_fixed) else $error("port zero settings changed");

  property p_reject_no_pass;
    @(posedge clk) disable iff (rst)
      (wr_cmd && cmd.op != opc_pkg::OPC_OP_EDIT && !is_nop && !unlocked_q)
        |=> (last_err_q && $stable(cfg_q[1]));
  endproperty
  a_reject_no_pass: assert property (p_reject_no_pass) else $error("reset ran unlocked");

  property p_reset_all;
    @(posedge clk) disable iff (rst)
      rsa_ok |=> (cfg_q[7].port_function_select == `OPC_RST_FN) &&
                 (cfg_q[3].stability_time == `OPC_RST_ST);
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("reset-all missed a port");

  property p_edit_one;
    @(posedge clk) disable iff (rst)
      (edit_ok && cmd.idx == 3'h2) |=> ($stable(cfg_q[5]) &&
        cfg_q[2].stability_time == $past(cmd.st));
  endproperty
  a_edit_one: assert property (p_edit_one) else $error("edit touched wrong port");

  property p_bad_idx;
    @(posedge clk) disable iff (rst)
      (wr_cmd && cmd.idx_bad && cmd.op == opc_pkg::OPC_OP_EDIT) |=> last_err_q;
  endproperty
  a_bad_idx: assert property (p_bad_idx) else $error("out of range port taken");

  sequence s_drop(int n);
    !detected[n];
  endsequence

  property p_drop_clears;
    @(posedge clk) disable iff (rst)
      s_drop(3) |=> !qualified[3] ##0 (port_out[3] == $past(cfg_q[3].output_logic_select));
  endproperty
  a_drop_clears: assert property (p_drop_clears) else $error("qualify held after drop");

  property p_zero_time;
    @(posedge clk) disable iff (rst)
      (detected[4] && cfg_q[4].stability_time == 14'h0000 && $stable(cfg_q[4]))
        |=> qualified[4];
  endproperty
  a_zero_time: assert property (p_zero_time) else $error("zero time delayed output");

  property p_none_idle;
    @(posedge clk) disable iff (rst)
      (cfg_q[6].port_function_select == `OPC_FN_NONE) |-> !detected[6];
  endproperty
  a_none_idle: assert property (p_none_idle) else $error("no-function port active");

  property p_polarity;
    @(posedge clk) disable iff (rst)
      ($stable(cfg_q[1]) && $stable(qualified[1]))
        |-> (port_out[1] == (qualified[1] ^ cfg_q[1].output_logic_select));
  endproperty
  a_polarity: assert property (p_polarity) else $error("output polarity wrong");

  // ----------------------------------------------------------------
  // Bus, unlock, edit, timing and output checks
  // ----------------------------------------------------------------
  sequence s_unlock;
    wr_pass && (wdata == `OPC_PASSWORD_KEY);
  endsequence

  sequence s_spend;
    unlocked_q && wr_cmd;
  endsequence

  property p_rdata_idle;
    @(posedge clk) disable iff (rst)
      !rd |=> (rdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data held too long");

  property p_unlock;
    @(posedge clk) disable iff (rst)
      s_unlock |=> unlocked_q;
  endproperty
  a_unlock: assert property (p_unlock) else $error("password did not unlock");

  // A single password must not cover two reset commands
  property p_unlock_once;
    @(posedge clk) disable iff (rst)
      s_spend |=> !unlocked_q;
  endproperty
  a_unlock_once: assert property (p_unlock_once) else $error("unlock outlived a command");

  property p_edit_refused;
    @(posedge clk) disable iff (rst)
      (wr_cmd && cmd.op == opc_pkg::OPC_OP_EDIT && !edit_ok)
        |=> (last_err_q && !last_ok_q && $stable(cfg_q[2]));
  endproperty
  a_edit_refused: assert property (p_edit_refused) else $error("refused edit applied");

  property p_port0_refuse;
    @(posedge clk) disable iff (rst)
      (wr_cmd && cmd.op == opc_pkg::OPC_OP_EDIT && cmd.idx == 3'h0 && !p0_fix)
        |=> $stable(cfg_q[0]);
  endproperty
  a_port0_refuse: assert property (p_port0_refuse) else $error("port zero edit taken");

  property p_edit_lands;
    @(posedge clk) disable iff (rst)
      (edit_ok && cmd.idx == 3'h5) |=>
        (cfg_q[5].port_function_select == $past(cmd.fn)) &&
        (cfg_q[5].output_logic_select == $past(cmd.pol));
  endproperty
  a_edit_lands: assert property (p_edit_lands) else $error("edit did not land");

  property p_tick_spacing;
    @(posedge clk) disable iff (rst)
      tick |=> (tick_cnt_q == 12'h000);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("time base out of step");

  // With a non-zero time the port cannot qualify on the first detected cycle
  property p_qual_needs_time;
    @(posedge clk) disable iff (rst)
      ($rose(qualified[4]) && cfg_q[4].stability_time != 14'h0000 && $stable(cfg_q[4]))
        |-> ($past(detected[4]) && $past(detected[4], 2));
  endproperty
  a_qual_needs_time: assert property (p_qual_needs_time) else $error("qualified too early");

  property p_closed_follow;
    @(posedge clk) disable iff (rst)
      (qualified[2] && !cfg_q[2].output_logic_select && $stable(cfg_q[2])) |-> port_out[2];
  endproperty
  a_closed_follow: assert property (p_closed_follow) else $error("port not closed");

endmodule

// ===== include/opc_params.svh
// Constants for the output port conditioner: offsets, field positions, resets, timing
`ifndef OPC_PARAMS_SVH
`define OPC_PARAMS_SVH

`define OPC_NUM_PORTS        8
`define OPC_PORT_IDX_MAX     7
// Register bus offsets (byte offsets on a plain port, 8-bit address)
`define OPC_ADDR_CMD         8'h00
`define OPC_ADDR_PORT_CFG    8'h04
`define OPC_ADDR_PASSWORD    8'h08
`define OPC_ADDR_STATUS      8'h0C
`define OPC_ADDR_OUT         8'h10
`define OPC_ADDR_CFG_RD      8'h14
// Command word fields
`define OPC_CMD_IDX_LSB      0
`define OPC_CMD_OP_LSB       4
`define OPC_CMD_FN_LSB       8
`define OPC_CMD_POL_BIT      13
`define OPC_CMD_ST_LSB       16
// Function codes: 0 none, 1..24 the status list
`define OPC_FN_NONE          5'h00
`define OPC_FN_DRIVER_READY  5'h01
`define OPC_FN_NORMAL_STATE  5'h16
`define OPC_FN_LAST          5'h18
// Factory defaults
`define OPC_RST_FN           5'h00
`define OPC_RST_FN_PORT0     5'h01
`define OPC_RST_POL          1'b0
`define OPC_RST_ST           14'h0000
`define OPC_PASSWORD_KEY     32'h0000A5A5
// Stability time in 0.1 ms units, 0.0 to 1000.0 ms
`define OPC_ST_MAX           14'h2710
`define OPC_CLK_HZ           25000000
`define OPC_ST_UNIT_NS       100000
`define OPC_CLK_NS           40
`define OPC_TICK_CYCLES      (`OPC_ST_UNIT_NS / `OPC_CLK_NS)

`endif

// ===== include/opc_pkg.sv
// Types for the output port conditioner
package opc_pkg;

  typedef enum logic [1:0] {
    OPC_OP_EDIT      = 2'h0,
    OPC_OP_RESET_ONE = 2'h1,
    OPC_OP_RESET_ALL = 2'h2,
    OPC_OP_NOP       = 2'h3
  } opc_op_t;

  typedef struct packed {
    logic [4:0]  port_function_select;
    logic        output_logic_select;
    logic [13:0] stability_time;
  } opc_port_cfg_t;

  typedef struct packed {
    logic [2:0] idx;
    opc_op_t    op;
    logic [4:0] fn;
    logic       pol;
    logic [13:0] st;
    logic       idx_bad;
  } opc_cmd_t;

endpackage

// ===== hdl/opc_stab_filter.sv
// One port's stability filter and polarity stage
`timescale 1ns/1ps
`include "opc_params.svh"

module opc_stab_filter (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        detected,
  input  wire logic [13:0] stability_time,
  input  wire logic        output_logic_select,
  output logic             port_closed,
  output logic             qualified
);

  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic        qual_q;
  logic        qual_d;
  logic        pin_q;
  wire         reached = (cnt_q >= stability_time);

  // Any drop of the condition restarts the count
  always_comb begin
    cnt_d  = cnt_q;
    qual_d = qual_q;
    if (!detected) begin
      cnt_d  = 14'h0000;
      qual_d = 1'b0;
    end else if (stability_time == 14'h0000) begin
      qual_d = 1'b1;
    end else if (reached) begin
      qual_d = 1'b1;
    end else if (tick) begin
      cnt_d = cnt_q + 14'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= 14'h0000;
      qual_q <= 1'b0;
      pin_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      qual_q <= qual_d;
      pin_q  <= qual_d ^ output_logic_select;
    end
  end

  assign port_closed = pin_q;
  assign qualified   = qual_q;

endmodule

// ===== dv/opc_ext_ctrl.sv
// Controller model that samples the conditioned output lines
`timescale 1ns/1ps

module opc_ext_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  port_out,
  output logic      [7:0]  seen_q,
  output logic      [15:0] n_close_q
);
  // No filter of its own: a line is taken as it stands at the rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_q    <= 8'h00;
      n_close_q <= 16'h0000;
    end else begin
      seen_q    <= port_out;
      n_close_q <= n_close_q + 16'(|(port_out & ~seen_q));
    end
  end
endmodule

// ===== dv/opc_top_bench.sv
// Self-checking bench for the output port conditioner
`timescale 1ns/1ps
`include "opc_params.svh"

module opc_top_bench;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [24:0] status_conditions;
  logic [7:0]  port_out;
  logic [7:0]  seen_q;
  logic [15:0] n_close_q;
  logic [31:0] v;
  int          n_mismatch;
  int          checked;
  int          k;

  localparam logic [1:0] ED = opc_pkg::OPC_OP_EDIT;
  localparam logic [1:0] R1P = opc_pkg::OPC_OP_RESET_ONE;
  localparam logic [1:0] RAL = opc_pkg::OPC_OP_RESET_ALL;

  opc_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .status_conditions(status_conditions), .port_out(port_out));
  opc_ext_ctrl ext (.clk(clk), .rst(rst), .port_out(port_out), .seen_q(seen_q),
    .n_close_q(n_close_q));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("Mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic [31:0] cmd(input logic [2:0] i, input logic [1:0] op,
      input logic [4:0] fn, input logic pol, input logic [13:0] st);
    return {2'h0, st, 2'h0, pol, fn, 2'h0, op, 1'b0, i};
  endfunction

  task automatic cfg_is(input logic [2:0] i, input logic [4:0] fn, input logic pol,
      input logic [13:0] st);
    logic [31:0] d;
    wr_reg(`OPC_ADDR_PORT_CFG, {29'h0, i});
    rd_reg(`OPC_ADDR_CFG_RD, d);
    chk(d, {2'h0, st, 2'h0, pol, fn, 8'h00}, "port cfg");
  endtask

  // Status low bits: 01 accepted, 10 refused
  task automatic do_cmd(input logic [31:0] c, input logic [1:0] e);
    logic [31:0] d;
    wr_reg(`OPC_ADDR_CMD, c);
    rd_reg(`OPC_ADDR_STATUS, d);
    chk(d & 32'h3, {30'h0, e}, "status");
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic cond(input int b, input logic l);
    @(posedge clk);
    status_conditions[b] <= l;
    settle();
  endtask

  task automatic out_is(input int p, input logic e);
    chk({31'h0, port_out[p]}, {31'h0, e}, "port out");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    status_conditions = 25'h0;
    n_mismatch = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cfg_is(3'h0, `OPC_RST_FN_PORT0, `OPC_RST_POL, `OPC_RST_ST);
    cfg_is(3'h3, `OPC_RST_FN, `OPC_RST_POL, `OPC_RST_ST);
    rd_reg(`OPC_ADDR_OUT, v);
    chk(v, 32'h0, "outputs idle");
    do_cmd(cmd(3'h2, ED, 5'h05, 1'b0, 14'h0), 2'b01);
    cfg_is(3'h2, 5'h05, 1'b0, 14'h0);
    cfg_is(3'h3, 5'h00, 1'b0, 14'h0);
    cond(5, 1'b1);
    out_is(2, 1'b1);
    rd_reg(`OPC_ADDR_OUT, v);
    chk(v, 32'h0404, "qualified and out");
    do_cmd(cmd(3'h2, ED, 5'h05, 1'b1, 14'h0), 2'b01);
    settle();
    out_is(2, 1'b0);
    cond(5, 1'b0);
    out_is(2, 1'b1);
    do_cmd(cmd(3'h2, ED, `OPC_FN_NONE, 1'b0, 14'h0), 2'b01);
    cond(5, 1'b1);
    out_is(2, 1'b0);
    do_cmd(cmd(3'h2, ED, 5'h05, 1'b0, 14'h0) | 32'h8, 2'b10);
    cfg_is(3'h2, 5'h00, 1'b0, 14'h0);
    do_cmd(cmd(3'h3, ED, 5'h19, 1'b0, 14'h0), 2'b10);
    do_cmd(cmd(3'h0, ED, 5'h05, 1'b0, 14'h0), 2'b10);
    do_cmd(cmd(3'h0, ED, 5'h01, 1'b1, 14'h0), 2'b10);
    do_cmd(cmd(3'h0, ED, 5'h01, 1'b0, 14'h1), 2'b10);
    cfg_is(3'h0, 5'h01, 1'b0, 14'h0);
    do_cmd(cmd(3'h0, ED, `OPC_FN_NORMAL_STATE, 1'b0, 14'h0), 2'b01);
    wr_reg(8'h20, 32'hFFFFFFFF);
    cfg_is(3'h0, `OPC_FN_NORMAL_STATE, 1'b0, 14'h0);
    cond(22, 1'b1);
    out_is(0, 1'b1);
    // Two ticks of stability; an interruption must restart the count
    do_cmd(cmd(3'h4, ED, 5'h07, 1'b0, 14'h2), 2'b01);
    cfg_is(3'h4, 5'h07, 1'b0, 14'h2);
    cond(7, 1'b1);
    repeat (2400) @(posedge clk);
    out_is(4, 1'b0);
    cond(7, 1'b0);
    cond(7, 1'b1);
    repeat (2400) @(posedge clk);
    out_is(4, 1'b0);
    k = 0;
    while (seen_q[4] !== 1'b1 && k < 2700) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, seen_q[4]}, 32'h1, "qualified late");
    cond(7, 1'b0);
    out_is(4, 1'b0);
    do_cmd(cmd(3'h4, R1P, 5'h00, 1'b0, 14'h0), 2'b10);
    cfg_is(3'h4, 5'h07, 1'b0, 14'h2);
    wr_reg(`OPC_ADDR_PASSWORD, `OPC_PASSWORD_KEY);
    rd_reg(`OPC_ADDR_STATUS, v);
    chk(v & 32'h4, 32'h4, "unlocked");
    do_cmd(cmd(3'h4, R1P, 5'h00, 1'b0, 14'h0), 2'b01);
    cfg_is(3'h4, 5'h00, 1'b0, 14'h0);
    cfg_is(3'h0, `OPC_FN_NORMAL_STATE, 1'b0, 14'h0);
    do_cmd(cmd(3'h3, ED, 5'h09, 1'b1, 14'h5), 2'b01);
    do_cmd(cmd(3'h0, RAL, 5'h00, 1'b0, 14'h0), 2'b10);
    cfg_is(3'h3, 5'h09, 1'b1, 14'h5);
    wr_reg(`OPC_ADDR_PASSWORD, `OPC_PASSWORD_KEY);
    do_cmd(cmd(3'h0, RAL, 5'h00, 1'b0, 14'h0), 2'b01);
    for (k = 0; k < `OPC_NUM_PORTS; k++) begin
      cfg_is(3'(k), (k == 0) ? `OPC_RST_FN_PORT0 : `OPC_RST_FN, 1'b0, 14'h0);
    end
    complete_run();
  end

  // Tests take about 8000 cycles; allow over seven times that
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("BAD t=%0t watchdog expired", $time);
    complete_run();
  end
endmodule
